// [core/servo_consts.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef SERVO_CONSTS_SVH
`define SERVO_CONSTS_SVH

`define CLK_HZ             25000000
`define CYC_PER_US         (`CLK_HZ / 1000000)
`define RAMP_RPM_SPAN      1000
`define RAMP_MAX_MS        10000
`define RAMP_CYC_PER_MS_RPM (`CLK_HZ / (1000 * `RAMP_RPM_SPAN))

`define RATE_DED_PPS       2000000
`define RATE_LD_PPS        500000
`define RATE_OC_PPS        200000

`define GEAR_NUM_MIN       1
`define GEAR_NUM_MAX       10000
`define GEAR_EXP_MAX       17

`define FIR_TAPS           8
`define FIR_SHIFT          3
`define FIR_SAMPLE_US      10

`define OFS_CTRL           8'h00
`define OFS_GEAR           8'h04
`define OFS_LAG            8'h08
`define OFS_ACC            8'h0C
`define OFS_DEC            8'h10
`define OFS_SPD0           8'h20
`define OFS_SPD7           8'h3C
`define OFS_STAT           8'h40
`define OFS_DEV            8'h44
`define OFS_CPOS           8'h48
`define OFS_VEL            8'h4C

`define CTRL_CFG_LSB       0
`define CTRL_FMT_LSB       4
`define CTRL_FILT_BIT      8
`define CTRL_TSW_BIT       9
`define CTRL_MSK_OT_BIT    12
`define CTRL_MSK_TL_BIT    13
`define CTRL_MSK_INH_BIT   14
`define CTRL_MSK_ZC_BIT    15
`define GEAR_EXP_LSB       16

`define RST_CTRL           32'h0000_0000
`define RST_GEAR_NUM       14'h0001
`define RST_GEAR_EXP       5'h00
`define RST_LAG            4'h4
`define RST_RAMP_MS        14'h0000
`define RST_SPD            16'h0000

`endif

// [core/servo_pkg.sv]
// Types shared by the command input logic
package servo_pkg;

   typedef enum logic [5:0] {
      CFG_POS     = 6'b00_0001,
      CFG_VEL     = 6'b00_0010,
      CFG_TRQ     = 6'b00_0100,
      CFG_POS_VEL = 6'b00_1000,
      CFG_POS_TRQ = 6'b01_0000,
      CFG_VEL_TRQ = 6'b10_0000
   } ctl_cfg_t;

   typedef enum logic [2:0] {
      ACT_POS = 3'b001,
      ACT_VEL = 3'b010,
      ACT_TRQ = 3'b100
   } ctl_act_t;

   typedef enum logic [1:0] {
      FMT_CW_CCW    = 2'h0,
      FMT_PULSE_DIR = 2'h1,
      FMT_QUAD      = 2'h2
   } pulse_fmt_t;

endpackage

// [core/pulse_decoder.sv]
// Decoder for two-line pulse or quadrature signals into single steps
`timescale 1ns/100ps
module pulse_decoder
   import servo_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       in_a,
   input  wire logic       in_b,
   input  wire pulse_fmt_t fmt,
   output logic            step_r,
   output logic            up_r
);
   logic a_q_r;
   logic b_q_r;
   logic a_rise;
   logic b_rise;
   logic step_nxt;
   logic up_nxt;

   assign a_rise = in_a & ~a_q_r;
   assign b_rise = in_b & ~b_q_r;

   // One edge per clock is enough: 2 Mpps leaves over 12 clocks per pulse
   always_comb begin
      step_nxt = 1'b0;
      up_nxt   = up_r;
      case (fmt)
         FMT_CW_CCW: begin
            if (a_rise && !b_rise) begin
               step_nxt = 1'b1;
               up_nxt   = 1'b1;
            end else if (b_rise && !a_rise) begin
               step_nxt = 1'b1;
               up_nxt   = 1'b0;
            end
         end
         FMT_PULSE_DIR: begin
            if (a_rise) begin
               step_nxt = 1'b1;
               up_nxt   = ~in_b;
            end
         end
         FMT_QUAD: begin
            if ((in_a ^ a_q_r) != (in_b ^ b_q_r)) begin
               step_nxt = 1'b1;
               up_nxt   = ~(a_q_r ^ in_b);
            end
         end
         default: begin
            step_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         a_q_r  <= 1'b0;
         b_q_r  <= 1'b0;
         step_r <= 1'b0;
         up_r   <= 1'b1;
      end else begin
         a_q_r  <= in_a;
         b_q_r  <= in_b;
         step_r <= step_nxt;
         up_r   <= up_nxt;
      end
   end
endmodule // pulse_decoder

// [core/velocity_ramp.sv]
// Velocity command ramp with separate acceleration and deceleration times
`timescale 1ns/100ps
`include "servo_consts.svh"
module velocity_ramp
   import servo_pkg::*;
#(
   parameter int CNT_W = 19
)
(
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   input  wire logic signed [15:0] target,
   input  wire logic        [13:0] acc_ms,
   input  wire logic        [13:0] dec_ms,
   output logic signed      [15:0] vel_r
);
   logic             accel;
   logic [13:0]      time_ms;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] cnt_r;

   // Moving away from zero speed uses the acceleration time
   assign accel = ((target > vel_r) && (vel_r >= 16'sh0000)) ||
                  ((target < vel_r) && (vel_r <= 16'sh0000));
   assign time_ms = accel ? acc_ms : dec_ms;
   // Time per 1000 r/min gives clocks per 1 r/min step
   assign period = CNT_W'(time_ms * `RAMP_CYC_PER_MS_RPM);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         vel_r <= 16'sh0000;
         cnt_r <= '0;
      end else if (vel_r == target) begin
         cnt_r <= '0;
      end else if (period == '0) begin
         vel_r <= target;
         cnt_r <= '0;
      end else if (cnt_r >= period - CNT_W'(1)) begin
         vel_r <= (target > vel_r) ? vel_r + 16'sh0001 : vel_r - 16'sh0001;
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + CNT_W'(1);
      end
   end
endmodule // velocity_ramp

// [core/servo_command_input_logic.sv]
// Command input logic of a servo drive: pulses, gear, filter, speeds
`timescale 1ns/100ps
`include "servo_consts.svh"
module servo_command_input_logic
   import servo_pkg::*;
#(
   parameter int POS_W  = 48,
   parameter int DEV_W  = 32,
   parameter int FIR_DIV = `FIR_SAMPLE_US * `CYC_PER_US
)
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        cmd_a,
   input  wire logic        cmd_b,
   input  wire logic        enc_a,
   input  wire logic        enc_b,
   input  wire logic        servo_on_in,
   input  wire logic        alarm_clr_in,
   input  wire logic        gain_tl_in,
   input  wire logic        mode_sw_in,
   input  wire logic        cw_inh_in,
   input  wire logic        ccw_inh_in,
   input  wire logic [3:0]  multi_in,
   output logic             servo_en_r,
   output logic             alarm_clr_r,
   output logic             gain_sel_r,
   output logic             tlim_sel_r,
   output logic             damp_sel_r,
   output logic             cw_stop_r,
   output logic             ccw_stop_r,
   output logic [2:0]       act_mode_r,
   output logic [31:0]      pos_ref_r,
   output logic [15:0]      vel_cmd_r,
   output logic [31:0]      dev_cnt_r
);
   // Configuration registers
   logic [2:0]         cfg_code_r;
   logic [1:0]         fmt_r;
   logic               filt_fir_r;
   logic               tsw_tlim_r;
   logic               msk_ot_r;
   logic               msk_tl_r;
   logic               msk_inh_r;
   logic               msk_zc_r;
   logic [13:0]        gear_num_r;
   logic [4:0]         gear_exp_r;
   logic [3:0]         lag_k_r;
   logic [13:0]        acc_ms_r;
   logic [13:0]        dec_ms_r;
   logic [15:0]        spd_r [8];

   // Datapath state
   logic signed [POS_W-1:0] cmd_pos_r;
   logic signed [POS_W-1:0] lag_r;
   logic signed [POS_W-1:0] fir_hist_r [`FIR_TAPS];
   logic signed [POS_W+2:0] fir_sum_r;
   logic [2:0]              fir_idx_r;
   logic [15:0]             fir_div_r;
   logic signed [POS_W-1:0] filt_q_r;
   logic signed [DEV_W-1:0] dev_r;
   logic                    vel_zc_r;

   // Bus slave
   logic        bus_req;
   logic        wr_go;
   logic [31:0] rd_nxt;

   // Decoded control
   ctl_cfg_t    cfg;
   ctl_act_t    act;
   logic        in_pos;
   logic        in_vel;
   logic        in_trq;
   logic        dev_clr;
   logic        inhibit;
   logic        zclamp;
   logic [2:0]  spd_sel;

   // Pulses and gear
   logic                    cmd_step;
   logic                    cmd_up;
   logic                    fb_step;
   logic                    fb_up;
   logic [13:0]             num_eff;
   logic [4:0]              exp_eff;
   logic [POS_W-1:0]        gear_inc;
   logic signed [POS_W-1:0] lag_diff;
   logic signed [POS_W-1:0] lag_step;
   logic signed [POS_W-1:0] lag_nxt;
   logic signed [POS_W-1:0] filt_nxt;
   logic signed [POS_W-1:0] filt_delta;
   logic signed [15:0]      vel_target;
   logic signed [15:0]      vel_ramped;

   assign bus_req = avs_read | avs_write;
   // A write lands on the one edge where waitrequest is seen low
   assign wr_go   = avs_write & ~avs_waitrequest;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~(bus_req & avs_waitrequest);
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_code_r <= 3'(`RST_CTRL);
         fmt_r      <= 2'h0;
         filt_fir_r <= 1'b0;
         tsw_tlim_r <= 1'b0;
         msk_ot_r   <= 1'b0;
         msk_tl_r   <= 1'b0;
         msk_inh_r  <= 1'b0;
         msk_zc_r   <= 1'b0;
         gear_num_r <= `RST_GEAR_NUM;
         gear_exp_r <= `RST_GEAR_EXP;
         lag_k_r    <= `RST_LAG;
         acc_ms_r   <= `RST_RAMP_MS;
         dec_ms_r   <= `RST_RAMP_MS;
         for (int i = 0; i < 8; i++) begin
            spd_r[i] <= `RST_SPD;
         end
      end else if (wr_go) begin
         if (avs_address == `OFS_CTRL) begin
            cfg_code_r <= avs_writedata[`CTRL_CFG_LSB +: 3];
            fmt_r      <= avs_writedata[`CTRL_FMT_LSB +: 2];
            filt_fir_r <= avs_writedata[`CTRL_FILT_BIT];
            tsw_tlim_r <= avs_writedata[`CTRL_TSW_BIT];
            msk_ot_r   <= avs_writedata[`CTRL_MSK_OT_BIT];
            msk_tl_r   <= avs_writedata[`CTRL_MSK_TL_BIT];
            msk_inh_r  <= avs_writedata[`CTRL_MSK_INH_BIT];
            msk_zc_r   <= avs_writedata[`CTRL_MSK_ZC_BIT];
         end else if (avs_address == `OFS_GEAR) begin
            gear_num_r <= avs_writedata[13:0];
            gear_exp_r <= avs_writedata[`GEAR_EXP_LSB +: 5];
         end else if (avs_address == `OFS_LAG) begin
            lag_k_r    <= avs_writedata[3:0];
         end else if (avs_address == `OFS_ACC) begin
            acc_ms_r   <= (avs_writedata[13:0] > 14'(`RAMP_MAX_MS)) ?
                          14'(`RAMP_MAX_MS) : avs_writedata[13:0];
         end else if (avs_address == `OFS_DEC) begin
            dec_ms_r   <= (avs_writedata[13:0] > 14'(`RAMP_MAX_MS)) ?
                          14'(`RAMP_MAX_MS) : avs_writedata[13:0];
         end else if (avs_address >= `OFS_SPD0 &&
                      avs_address <= `OFS_SPD7 &&
                      avs_address[1:0] == 2'h0) begin
            spd_r[avs_address[4:2]] <= avs_writedata[15:0];
         end
      end
   end

   // Read data is prepared while waitrequest is high and held until the next read
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (avs_address == `OFS_CTRL) begin
         rd_nxt[`CTRL_CFG_LSB +: 3] = cfg_code_r;
         rd_nxt[`CTRL_FMT_LSB +: 2] = fmt_r;
         rd_nxt[`CTRL_FILT_BIT]     = filt_fir_r;
         rd_nxt[`CTRL_TSW_BIT]      = tsw_tlim_r;
         rd_nxt[`CTRL_MSK_OT_BIT]   = msk_ot_r;
         rd_nxt[`CTRL_MSK_TL_BIT]   = msk_tl_r;
         rd_nxt[`CTRL_MSK_INH_BIT]  = msk_inh_r;
         rd_nxt[`CTRL_MSK_ZC_BIT]   = msk_zc_r;
      end else if (avs_address == `OFS_GEAR) begin
         rd_nxt[13:0]                 = gear_num_r;
         rd_nxt[`GEAR_EXP_LSB +: 5]   = gear_exp_r;
      end else if (avs_address == `OFS_LAG) begin
         rd_nxt[3:0] = lag_k_r;
      end else if (avs_address == `OFS_ACC) begin
         rd_nxt[13:0] = acc_ms_r;
      end else if (avs_address == `OFS_DEC) begin
         rd_nxt[13:0] = dec_ms_r;
      end else if (avs_address >= `OFS_SPD0 &&
                   avs_address <= `OFS_SPD7 &&
                   avs_address[1:0] == 2'h0) begin
         rd_nxt[15:0] = spd_r[avs_address[4:2]];
      end else if (avs_address == `OFS_STAT) begin
         rd_nxt[2:0] = act;
         rd_nxt[3]   = zclamp;
         rd_nxt[4]   = inhibit;
         rd_nxt[5]   = dev_clr;
         rd_nxt[6]   = servo_en_r;
      end else if (avs_address == `OFS_DEV) begin
         rd_nxt = 32'(dev_r);
      end else if (avs_address == `OFS_CPOS) begin
         rd_nxt = cmd_pos_r[31:0];
      end else if (avs_address == `OFS_VEL) begin
         rd_nxt = {{16{vel_cmd_r[15]}}, vel_cmd_r};
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= rd_nxt;
      end
   end

   // Unknown codes fall back to plain position control
   always_comb begin
      case (cfg_code_r)
         3'h1:    cfg = CFG_VEL;
         3'h2:    cfg = CFG_TRQ;
         3'h3:    cfg = CFG_POS_VEL;
         3'h4:    cfg = CFG_POS_TRQ;
         3'h5:    cfg = CFG_VEL_TRQ;
         default: cfg = CFG_POS;
      endcase
   end

   always_comb begin
      case (cfg)
         CFG_VEL:     act = ACT_VEL;
         CFG_TRQ:     act = ACT_TRQ;
         CFG_POS_VEL: act = mode_sw_in ? ACT_VEL : ACT_POS;
         CFG_POS_TRQ: act = mode_sw_in ? ACT_TRQ : ACT_POS;
         CFG_VEL_TRQ: act = mode_sw_in ? ACT_TRQ : ACT_VEL;
         default:     act = ACT_POS;
      endcase
   end

   assign in_pos  = (act == ACT_POS);
   assign in_vel  = (act == ACT_VEL);
   assign in_trq  = (act == ACT_TRQ);
   // The multipurpose pins change meaning with the active mode
   assign dev_clr = in_pos & multi_in[0];
   assign inhibit = in_pos & multi_in[1] & ~msk_inh_r;
   assign zclamp  = (in_vel | in_trq) & multi_in[0] & ~msk_zc_r;
   assign spd_sel = in_vel ? multi_in[3:1] : 3'h0;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         servo_en_r  <= 1'b0;
         alarm_clr_r <= 1'b0;
         gain_sel_r  <= 1'b0;
         tlim_sel_r  <= 1'b0;
         damp_sel_r  <= 1'b0;
         cw_stop_r   <= 1'b0;
         ccw_stop_r  <= 1'b0;
         act_mode_r  <= ACT_POS;
      end else begin
         servo_en_r  <= servo_on_in;
         alarm_clr_r <= alarm_clr_in;
         gain_sel_r  <= gain_tl_in & ~tsw_tlim_r;
         tlim_sel_r  <= gain_tl_in & tsw_tlim_r & ~msk_tl_r;
         damp_sel_r  <= in_pos & multi_in[2];
         cw_stop_r   <= cw_inh_in & ~msk_ot_r;
         ccw_stop_r  <= ccw_inh_in & ~msk_ot_r;
         act_mode_r  <= act;
      end
   end

   pulse_decoder u_cmd_dec (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .in_a     (cmd_a),
      .in_b     (cmd_b),
      .fmt      (pulse_fmt_t'(fmt_r)),
      .step_r   (cmd_step),
      .up_r     (cmd_up)
   );

   // Encoder feedback is always quadrature
   pulse_decoder u_fb_dec (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .in_a     (enc_a),
      .in_b     (enc_b),
      .fmt      (FMT_QUAD),
      .step_r   (fb_step),
      .up_r     (fb_up)
   );

   // Out-of-range gear values are clamped rather than rejected
   assign num_eff = (gear_num_r < 14'(`GEAR_NUM_MIN)) ? 14'(`GEAR_NUM_MIN) :
                    (gear_num_r > 14'(`GEAR_NUM_MAX)) ? 14'(`GEAR_NUM_MAX) :
                    gear_num_r;
   assign exp_eff = (gear_exp_r > 5'(`GEAR_EXP_MAX)) ?
                    5'(`GEAR_EXP_MAX) : gear_exp_r;
   assign gear_inc = POS_W'(num_eff) << exp_eff;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_pos_r <= '0;
      end else if (cmd_step && !inhibit && in_pos) begin
         cmd_pos_r <= cmd_up ? cmd_pos_r + gear_inc
                             : cmd_pos_r - gear_inc;
      end
   end

   // First-order lag; a residue below one step is still walked out
   assign lag_diff = cmd_pos_r - lag_r;
   assign lag_step = lag_diff >>> lag_k_r;
   assign lag_nxt  = (lag_step != '0) ? lag_r + lag_step :
                     (lag_diff > 0)   ? lag_r + POS_W'(1) :
                     (lag_diff < 0)   ? lag_r - POS_W'(1) : lag_r;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lag_r <= '0;
      end else begin
         lag_r <= lag_nxt;
      end
   end

   // Moving average over the last taps, sampled at a fixed period
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < `FIR_TAPS; i++) begin
            fir_hist_r[i] <= '0;
         end
         fir_sum_r <= '0;
         fir_idx_r <= 3'h0;
         fir_div_r <= 16'h0000;
      end else if (fir_div_r >= 16'(FIR_DIV - 1)) begin
         fir_div_r             <= 16'h0000;
         fir_hist_r[fir_idx_r] <= cmd_pos_r;
         fir_sum_r             <= fir_sum_r + (POS_W+3)'(cmd_pos_r)
                                  - (POS_W+3)'(fir_hist_r[fir_idx_r]);
         fir_idx_r             <= fir_idx_r + 3'h1;
      end else begin
         fir_div_r <= fir_div_r + 16'h0001;
      end
   end

   assign filt_nxt   = filt_fir_r ? POS_W'(fir_sum_r >>> `FIR_SHIFT)
                                  : lag_r;
   assign filt_delta = filt_nxt - filt_q_r;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         filt_q_r <= '0;
         dev_r    <= '0;
      end else begin
         filt_q_r <= filt_nxt;
         if (dev_clr) begin
            dev_r <= '0;
         end else if (fb_step) begin
            dev_r <= dev_r + DEV_W'(filt_delta)
                     - (fb_up ? DEV_W'(1) : -DEV_W'(1));
         end else begin
            dev_r <= dev_r + DEV_W'(filt_delta);
         end
      end
   end

   // Zero clamp wins over any selected speed
   assign vel_target = zclamp ? 16'sh0000 : spd_r[spd_sel];

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         vel_zc_r <= 1'b0;
      end else begin
         vel_zc_r <= zclamp;
      end
   end

   velocity_ramp #(
      .CNT_W (19)
   ) u_ramp (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .target   (vel_target),
      .acc_ms   (acc_ms_r),
      .dec_ms   (dec_ms_r),
      .vel_r    (vel_ramped)
   );

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pos_ref_r <= 32'h0000_0000;
         vel_cmd_r <= 16'h0000;
         dev_cnt_r <= 32'h0000_0000;
      end else begin
         pos_ref_r <= filt_q_r[31:0];
         vel_cmd_r <= (vel_zc_r && zclamp) ? 16'h0000 : vel_ramped;
         dev_cnt_r <= 32'(dev_r);
      end
   end
endmodule // servo_command_input_logic

// [test/pulse_src.sv]
// Motion controller model driving the two command pulse lines
`timescale 1ns/100ps
module pulse_src
   import servo_pkg::*;
(
   input  wire logic core_clk,
   output logic      out_a,
   output logic      out_b
);
   // Seven clocks a level keeps the rate just under 2 Mpps
   localparam int HOLD = 7;
   initial out_a = 1'b0;
   initial out_b = 1'b0;
   task automatic put(input logic ln, input logic v);
      repeat (HOLD) @(posedge core_clk);
      if (ln)
         out_b <= v;
      else
         out_a <= v;
   endtask
   // Quadrature sends four edges for each pulse asked for
   task automatic send(input pulse_fmt_t f, input logic rev, input int n);
      repeat (n) begin
         case (f)
            FMT_QUAD: begin
               put(rev, 1'b1);
               put(!rev, 1'b1);
               put(rev, 1'b0);
               put(!rev, 1'b0);
            end
            FMT_PULSE_DIR: begin
               put(1'b1, rev);
               put(1'b0, 1'b1);
               put(1'b0, 1'b0);
            end
            default: begin
               put(rev, 1'b1);
               put(rev, 1'b0);
            end
         endcase
      end
      put(1'b1, 1'b0);
   endtask
endmodule // pulse_src

// [test/servo_cmd_chk_sva.sv]
// Port assertions for the servo command input logic
`timescale 1ns/100ps
module servo_cmd_chk (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic        servo_on_in,
   input wire logic        gain_tl_in,
   input wire logic        cw_inh_in,
   input wire logic [3:0]  multi_in,
   input wire logic        servo_en_r,
   input wire logic        gain_sel_r,
   input wire logic        tlim_sel_r,
   input wire logic        cw_stop_r,
   input wire logic [2:0]  act_mode_r,
   input wire logic [31:0] dev_cnt_r
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   a_bus_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus access not answered");
   a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer too long");
   a_bus_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
      else $error("bus answer without access");
   a_servo_copy: assert property (servo_en_r == $past(servo_on_in))
      else $error("servo enable not copied");
   a_gain_route: assert property (gain_sel_r || tlim_sel_r |->
      $past(gain_tl_in) && !(gain_sel_r && tlim_sel_r))
      else $error("gain routing wrong");
   a_ot_cause: assert property (cw_stop_r |-> $past(cw_inh_in))
      else $error("stop without inhibit");
   a_mode_hot: assert property ($onehot(act_mode_r))
      else $error("mode not one-hot");
   a_dev_clear: assert property (
      (multi_in[0] && act_mode_r == 3'h1)[*4]
      |=> dev_cnt_r == 32'h0000_0000)
      else $error("deviation not cleared");
endmodule // servo_cmd_chk

// [test/servo_command_input_logic_tb.sv]
// Self-checking bench for the servo command input logic
`timescale 1ns/100ps
module servo_command_input_logic_tb
   import servo_pkg::*;
;
   logic        core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic        cmd_a, cmd_b, servo_on_in, gain_tl_in, mode_sw_in;
   logic        cw_inh_in, servo_en_r, alarm_clr_r, gain_sel_r;
   logic        tlim_sel_r, damp_sel_r, cw_stop_r, ccw_stop_r;
   logic [2:0]  act_mode_r;
   logic [3:0]  multi_in;
   logic [7:0]  avs_address;
   logic [15:0] vel_cmd_r;
   logic [31:0] avs_writedata, avs_readdata, pos_ref_r, dev_cnt_r, rd, pos;
   int          fail_count, checks_done, cyc;
   wire  [6:0]  outs;
   assign outs = {alarm_clr_r, ccw_stop_r, servo_en_r, gain_sel_r,
                  tlim_sel_r, cw_stop_r, damp_sel_r};
   // Command lines double as encoder so deviation sees real feedback
   servo_command_input_logic #(.FIR_DIV(4)) u_servo_command_input_logic (
      .*, .enc_a(cmd_a), .enc_b(cmd_b), .alarm_clr_in(servo_on_in),
      .ccw_inh_in(cw_inh_in));
   pulse_src u_cmd_src (.core_clk, .out_a(cmd_a), .out_b(cmd_b));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk(input string s, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask
   // Request stays up until waitrequest is seen low at an edge
   task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do
         @(posedge core_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      tick(1);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_regs();
      bus(1'b0, 8'h08, 32'h0000_0000);
      chk("lag reset", 32'h0000_0004, rd);
      bus(1'b1, 8'h04, 32'h001F_3FFF);
      bus(1'b0, 8'h04, 32'h0000_0000);
      chk("gear raw", 32'h001F_3FFF, rd);
      bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
      bus(1'b0, 8'hFC, 32'h0000_0000);
      chk("unmapped", 32'h0000_0000, rd);
      $display("register test done");
   endtask
   task automatic t_modes();
      logic [2:0] am [12] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4,
                              3'h1, 3'h2, 3'h1, 3'h4, 3'h2, 3'h4};
      for (int i = 0; i < 12; i++) begin
         mode_sw_in <= i[0];
         bus(1'b1, 8'h00, 32'(i / 2));
         tick(4);
         chk("active mode", 32'(am[i]), 32'(act_mode_r));
      end
      servo_on_in <= 1'b1;
      gain_tl_in <= 1'b1;
      cw_inh_in <= 1'b1;
      multi_in <= 4'h4;
      bus(1'b1, 8'h00, 32'h0000_0000);
      tick(4);
      chk("position inputs", 32'h0000_007B, 32'(outs));
      bus(1'b1, 8'h00, 32'h0000_1200);
      tick(4);
      chk("masked inputs", 32'h0000_0055, 32'(outs));
      bus(1'b1, 8'h00, 32'h0000_0001);
      tick(4);
      chk("velocity inputs", 32'h0000_007A, 32'(outs));
      gain_tl_in <= 1'b0;
      cw_inh_in <= 1'b0;
      multi_in <= 4'h0;
      $display("mode test done");
   endtask
   task automatic t_pulse();
      bus(1'b1, 8'h04, 32'h0002_0003);
      for (int f = 0; f < 3; f++) begin
         bus(1'b1, 8'h00, 32'h0000_0100 | 32'(f << 4));
         u_cmd_src.send(pulse_fmt_t'(f), 1'b0, 5);
         u_cmd_src.send(pulse_fmt_t'(f), 1'b1, 2);
         pos += (f == 2) ? 32'h0000_0090 : 32'h0000_0024;
         tick(60);
         chk("command position", pos, pos_ref_r);
      end
      // Only the quadrature round leaves net encoder counts: 3 x 4
      chk("deviation", pos - 32'h0000_000C, dev_cnt_r);
      multi_in <= 4'h2;
      u_cmd_src.send(FMT_QUAD, 1'b0, 2);
      tick(60);
      chk("inhibited", pos, pos_ref_r);
      bus(1'b1, 8'h00, 32'h0000_4120);
      u_cmd_src.send(FMT_QUAD, 1'b0, 1);
      pos += 32'h0000_0030;
      tick(60);
      chk("inhibit masked", pos, pos_ref_r);
      multi_in <= 4'h1;
      tick(8);
      chk("deviation clear", 32'h0000_0000, dev_cnt_r);
      multi_in <= 4'h0;
      $display("pulse test done");
   endtask
   task automatic t_speed();
      bus(1'b1, 8'h00, 32'h0000_0001);
      bus(1'b1, 8'h0C, 32'h0000_0000);
      for (int i = 0; i < 8; i++)
         bus(1'b1, 8'h20 + 8'(4 * i), 32'(100 * i + 7));
      chk("lag output", pos, pos_ref_r);
      for (int i = 0; i < 8; i++) begin
         multi_in <= 4'(2 * i);
         tick(6);
         chk("speed", 32'(100 * i + 7), 32'(vel_cmd_r));
      end
      multi_in <= 4'hF;
      tick(6);
      chk("zero clamp", 32'h0000_0000, 32'(vel_cmd_r));
      bus(1'b1, 8'h0C, 32'h0000_0001);
      bus(1'b1, 8'h10, 32'h0000_0002);
      // Mid-ramp windows tell the two ramp times apart
      multi_in <= 4'h2;
      tick(1500);
      chk("accel mid", 32'h1, 32'(vel_cmd_r > 40 && vel_cmd_r < 80));
      tick(1300);
      chk("accel end", 32'h0000_006B, 32'(vel_cmd_r));
      multi_in <= 4'h0;
      tick(2500);
      chk("decel mid", 32'h1, 32'(vel_cmd_r > 40 && vel_cmd_r < 80));
      tick(2700);
      chk("decel end", 32'h0000_0007, 32'(vel_cmd_r));
      $display("speed test done");
   endtask
   initial begin
      {sys_rst, avs_read, avs_write, servo_on_in, gain_tl_in} = 5'h10;
      {mode_sw_in, cw_inh_in, multi_in, avs_address, avs_writedata} = '0;
      pos = '0;
      tick(6);
      sys_rst <= 1'b0;
      tick(1);
      t_regs();
      t_modes();
      t_pulse();
      t_speed();
      give_verdict();
   end
endmodule // servo_command_input_logic_tb

bind servo_command_input_logic servo_cmd_chk u_servo_cmd_chk (.*);
